//--- shared/clk_ctrl_pkg.sv
// Purpose: Shared constants and carriers for the clock output control bytes
// Assumes: Byte registers reached through a command-code byte port
// Notes:   Byte 6 bits 2..0 are never stored; they come from the strap latch
package clk_ctrl_pkg;
  localparam logic [6:0] OFS_B2 = 7'h02;
  localparam logic [6:0] OFS_B3 = 7'h03;
  localparam logic [6:0] OFS_B4 = 7'h04;
  localparam logic [6:0] OFS_B5 = 7'h05;
  localparam logic [6:0] OFS_B6 = 7'h06;
  localparam logic [6:0] OFS_BLOCK = 7'h00;
  localparam logic [6:0] PTR_STEP = 7'h01;
  localparam int CMD_BYTE_BIT = 7;
  localparam logic [7:0] RST_B2 = 8'hFF;
  localparam logic [7:0] RST_B3 = 8'h00;
  localparam logic [7:0] RST_B4 = 8'h07;
  localparam logic [7:0] RST_B5 = 8'h00;
  localparam logic [7:0] RST_B6 = 8'h38;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam logic [2:0] STRAP_RST = 3'h0;
  localparam logic [7:0] B6_STORE_MASK = 8'hF8;
  localparam int B2_CPU2_EN = 1;
  localparam int B4_PANEL_PD = 7;
  localparam int B4_DOT_PD = 6;
  localparam int B4_FREE_STOP = 3;
  localparam int B5_REF_STOP_HIZ = 7;
  localparam int B5_UPPER_PD_HIZ = 3;
  localparam int B6_TEST_SEL = 7;
  localparam int B6_TEST_MODE = 6;
  localparam int B6_SW_RUN = 3;

  typedef struct packed {
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
  } cfg_t;

  typedef struct packed {
    logic [3:0] bus_stop;
    logic       free_bus_stop;
    logic [7:0] ref_stop;
    logic [7:0] ref_hiz;
    logic [2:0] cpu_stop;
    logic [2:0] cpu_hiz;
    logic       upper_pd_hiz;
    logic       panel_hiz;
    logic       dot_hiz;
  } stop_t;
endpackage

//--- hw/clock_output_control_regs.sv
// Purpose: Control bytes 2..6 of a clock generator, host view and output view
// Assumes: out_clk_edge pulses one mclk cycle at each output clock boundary
// Notes:   Host writes land in a shadow copy; outputs follow it at boundaries
`timescale 1ns/1ns
`default_nettype none
module clock_output_control_regs
  import clk_ctrl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       acc_start,
  input  wire logic [7:0] acc_cmd,
  input  wire logic       acc_wr,
  input  wire logic [7:0] acc_wdata,
  input  wire logic       acc_rd,
  output var  logic [7:0] acc_rdata,
  output var  logic       acc_rvalid,
  input  wire logic       out_clk_edge,
  input  wire logic       bus_clock_halt_n,
  input  wire logic       processor_clock_halt_n,
  input  wire logic       power_down_input,
  input  wire logic       supply_good_n,
  input  wire logic       freq_strap_a,
  input  wire logic       freq_strap_b,
  input  wire logic       freq_strap_c,
  output var  cfg_t       cfg,
  output var  stop_t      stop,
  output var  logic [2:0] straps
);

  typedef struct packed {
    cfg_t       shadow;
    cfg_t       cfg;
    stop_t      stop;
    logic [2:0] straps;
    logic       strap_taken;
    logic [6:0] ptr;
    logic       byte_mode;
    logic [7:0] rdata;
    logic       rvalid;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [7:0] read_byte(input cfg_t c, input logic [6:0] ofs, input logic [2:0] st);
    logic [7:0] v;
    v = READ_NONE;
    unique case (ofs)
      OFS_B2:  v = c.b2;
      OFS_B3:  v = c.b3;
      OFS_B4:  v = c.b4;
      OFS_B5:  v = c.b5;
      OFS_B6:  v = (c.b6 & B6_STORE_MASK) | {5'h00, st};
      default: v = READ_NONE;
    endcase
    return v;
  endfunction

  logic bus_halt;
  logic cpu_halt;
  logic [6:0] acc_ofs;

  always_comb begin
    next_s = s;
    acc_ofs = s.ptr;
    next_s.rvalid = 1'b0;
    // Command code picks byte or block access
    if (acc_start) begin
      next_s.byte_mode = acc_cmd[CMD_BYTE_BIT];
      next_s.ptr = acc_cmd[CMD_BYTE_BIT] ? acc_cmd[6:0] : OFS_BLOCK;
    end else if ((acc_wr || acc_rd) && !s.byte_mode) begin
      next_s.ptr = s.ptr + PTR_STEP;
    end
    if (acc_wr && !acc_start) begin
      unique case (acc_ofs)
        OFS_B2:  next_s.shadow.b2 = acc_wdata;
        OFS_B3:  next_s.shadow.b3 = acc_wdata;
        OFS_B4:  next_s.shadow.b4 = acc_wdata;
        OFS_B5:  next_s.shadow.b5 = acc_wdata;
        // Strap bits are dropped on write
        OFS_B6:  next_s.shadow.b6 = acc_wdata & B6_STORE_MASK;
        default: next_s.shadow = s.shadow;
      endcase
    end
    if (acc_rd && !acc_start) begin
      next_s.rdata = read_byte(s.shadow, acc_ofs, s.straps);
      next_s.rvalid = 1'b1;
    end
    // Straps caught once while supply good is asserted
    if (!s.strap_taken && !supply_good_n) begin
      next_s.straps = {freq_strap_c, freq_strap_b, freq_strap_a};
      next_s.strap_taken = 1'b1;
    end
    // Output view follows the shadow only at a boundary
    if (out_clk_edge) begin
      next_s.cfg = s.shadow;
    end
    bus_halt = !bus_clock_halt_n || !next_s.cfg.b6[B6_SW_RUN];
    cpu_halt = !processor_clock_halt_n;
    next_s.stop.bus_stop = {4{bus_halt}};
    next_s.stop.free_bus_stop = bus_halt && next_s.cfg.b4[B4_FREE_STOP];
    next_s.stop.ref_stop = next_s.cfg.b3 & {8{bus_halt}};
    next_s.stop.ref_hiz = next_s.stop.ref_stop & {8{next_s.cfg.b5[B5_REF_STOP_HIZ]}};
    next_s.stop.cpu_stop = next_s.cfg.b4[2:0] & {3{cpu_halt}};
    next_s.stop.cpu_hiz = (next_s.stop.cpu_stop & next_s.cfg.b5[6:4])
                        | (next_s.cfg.b5[2:0] & {3{power_down_input}});
    next_s.stop.upper_pd_hiz = power_down_input && next_s.cfg.b5[B5_UPPER_PD_HIZ];
    next_s.stop.panel_hiz = power_down_input && next_s.cfg.b4[B4_PANEL_PD];
    next_s.stop.dot_hiz = power_down_input && next_s.cfg.b4[B4_DOT_PD];
    if (!rst_b) begin
      next_s = '0;
      next_s.shadow = '{b2: RST_B2, b3: RST_B3, b4: RST_B4, b5: RST_B5, b6: RST_B6};
      next_s.cfg = next_s.shadow;
      next_s.straps = STRAP_RST;
      next_s.rdata = READ_NONE;
      next_s.ptr = OFS_BLOCK;
    end
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  always_comb begin
    acc_rdata = s.rdata;
    acc_rvalid = s.rvalid;
    cfg = s.cfg;
    stop = s.stop;
    straps = s.straps;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence byte_cmd_s;
    acc_start && acc_cmd[CMD_BYTE_BIT];
  endsequence
  sequence byte_write_s;
    byte_cmd_s ##1 !acc_wr ##1 (acc_wr && !acc_start && s.ptr == OFS_B3);
  endsequence
  sequence sw_halt_written_s;
    acc_wr && !acc_start && s.ptr == OFS_B6 && !acc_wdata[B6_SW_RUN];
  endsequence
  sequence sw_run_written_s;
    acc_wr && !acc_start && s.ptr == OFS_B6 && acc_wdata[B6_SW_RUN];
  endsequence
  sequence quiet_boundary_s;
    !acc_wr ##1 (out_clk_edge && !acc_wr);
  endsequence

  chk_reset_values: assert property ($past(!rst_b) |-> s.shadow.b2 == RST_B2 && s.shadow.b4 == RST_B4
    && s.shadow.b6 == RST_B6)
    else $error("reset values wrong");
  chk_byte_write_lands: assert property (byte_write_s |=> s.shadow.b3 == $past(acc_wdata))
    else $error("byte write missed offset");
  chk_block_ptr_step: assert property (acc_wr && !acc_start && !s.byte_mode |=> s.ptr == $past(s.ptr) + PTR_STEP)
    else $error("block pointer did not advance");
  chk_strap_readonly: assert property (acc_rd && !acc_start && s.ptr == OFS_B6 |=> acc_rvalid
    && acc_rdata[2:0] == $past(s.straps))
    else $error("strap readback wrong");
  chk_hold_between: assert property (!out_clk_edge |=> $stable(cfg))
    else $error("output view changed off boundary");
  chk_apply_boundary: assert property (out_clk_edge |=> cfg == $past(s.shadow))
    else $error("boundary did not apply shadow");
  chk_ref_stop_gate: assert property (##1 stop.ref_stop == (cfg.b3
    & {8{$past(!bus_clock_halt_n) || !cfg.b6[B6_SW_RUN]}}))
    else $error("reference stop mismatch");
  chk_sw_halt_bus: assert property (##1 (!cfg.b6[B6_SW_RUN] |-> stop.bus_stop == 4'hF))
    else $error("software halt missed bus clocks");
  chk_cpu_stop_gate: assert property (##1 stop.cpu_stop == (cfg.b4[2:0] & {3{$past(!processor_clock_halt_n)}}))
    else $error("processor stop mismatch");
  chk_unmapped_zero: assert property (acc_rd && !acc_start && s.ptr > OFS_B6 |=> acc_rdata == READ_NONE)
    else $error("unmapped read not zero");
  chk_bus_stop_gate: assert property ($past(rst_b) |->
    stop.bus_stop == {4{$past(!bus_clock_halt_n) || !cfg.b6[B6_SW_RUN]}})
    else $error("bus stop mismatch");
  chk_free_stop_gate: assert property ($past(rst_b) |->
    stop.free_bus_stop == (($past(!bus_clock_halt_n) || !cfg.b6[B6_SW_RUN]) && cfg.b4[B4_FREE_STOP]))
    else $error("free bus stop mismatch");
  chk_ref_hiz_gate: assert property ($past(rst_b) |->
    stop.ref_hiz == (stop.ref_stop & {8{cfg.b5[B5_REF_STOP_HIZ]}}))
    else $error("reference tri-state mismatch");
  chk_cpu_hiz_gate: assert property ($past(rst_b) |->
    stop.cpu_hiz == ((stop.cpu_stop & cfg.b5[6:4]) | (cfg.b5[2:0] & {3{$past(power_down_input)}})))
    else $error("processor tri-state mismatch");
  chk_upper_pd_gate: assert property ($past(rst_b) |->
    stop.upper_pd_hiz == ($past(power_down_input) && cfg.b5[B5_UPPER_PD_HIZ]))
    else $error("upper pair power-down mismatch");
  chk_panel_pd_gate: assert property ($past(rst_b) |->
    stop.panel_hiz == ($past(power_down_input) && cfg.b4[B4_PANEL_PD]))
    else $error("panel power-down mismatch");
  chk_dot_pd_gate: assert property ($past(rst_b) |->
    stop.dot_hiz == ($past(power_down_input) && cfg.b4[B4_DOT_PD]))
    else $error("dot power-down mismatch");
  chk_ref_free_run: assert property ($past(rst_b) && cfg.b3 == 8'h00 |->
    stop.ref_stop == 8'h00)
    else $error("free reference pair stopped");
  chk_cpu_free_run: assert property ($past(rst_b && processor_clock_halt_n) |->
    stop.cpu_stop == 3'h0)
    else $error("processor pair stopped without halt");
  chk_no_pd_hiz: assert property ($past(rst_b && !power_down_input) |->
    !stop.panel_hiz && !stop.dot_hiz && !stop.upper_pd_hiz)
    else $error("tri-state outside power down");
  chk_shadow_strap_bits: assert property (s.shadow.b6[2:0] == 3'h0
    )
    else $error("strap bits stored in shadow");
  chk_cfg_strap_bits: assert property (cfg.b6[2:0] == 3'h0
    )
    else $error("strap bits reached output view");
  chk_straps_hold: assert property (s.strap_taken |=>
    $stable(straps))
    else $error("latched straps changed");
  chk_strap_capture: assert property (!s.strap_taken && !supply_good_n |=>
    s.strap_taken && straps == $past({freq_strap_c, freq_strap_b, freq_strap_a}))
    else $error("straps not captured");
  chk_rvalid_pulse: assert property (acc_rd && !acc_start |=>
    acc_rvalid)
    else $error("read not answered");
  chk_rvalid_only_read: assert property (!(acc_rd && !acc_start) |=>
    !acc_rvalid)
    else $error("read valid without read");
  chk_rdata_hold: assert property (!(acc_rd && !acc_start) |=>
    $stable(acc_rdata))
    else $error("read data changed without read");
  chk_byte_cmd_ptr: assert property (byte_cmd_s |=>
    s.byte_mode && s.ptr == $past(acc_cmd[6:0]))
    else $error("byte command offset not taken");
  chk_block_cmd_ptr: assert property (acc_start && !acc_cmd[CMD_BYTE_BIT] |=>
    !s.byte_mode && s.ptr == OFS_BLOCK)
    else $error("block command pointer not cleared");
  chk_byte_ptr_fixed: assert property (!acc_start && s.byte_mode |=>
    s.ptr == $past(s.ptr))
    else $error("byte pointer moved");
  chk_block_rd_step: assert property (acc_rd && !acc_start && !s.byte_mode |=>
    s.ptr == $past(s.ptr) + PTR_STEP)
    else $error("block read pointer did not advance");
  chk_write_b2: assert property (acc_wr && !acc_start && s.ptr == OFS_B2 |=>
    s.shadow.b2 == $past(acc_wdata))
    else $error("byte 2 write missed");
  chk_write_b4: assert property (acc_wr && !acc_start && s.ptr == OFS_B4 |=>
    s.shadow.b4 == $past(acc_wdata))
    else $error("byte 4 write missed");
  chk_write_b5: assert property (acc_wr && !acc_start && s.ptr == OFS_B5 |=>
    s.shadow.b5 == $past(acc_wdata))
    else $error("byte 5 write missed");
  chk_write_b6: assert property (acc_wr && !acc_start && s.ptr == OFS_B6 |=>
    s.shadow.b6 == ($past(acc_wdata) & B6_STORE_MASK))
    else $error("byte 6 write missed");
  chk_unmapped_write: assert property (acc_wr && !acc_start && (s.ptr < OFS_B2 || s.ptr > OFS_B6) |=>
    $stable(s.shadow))
    else $error("unmapped write changed registers");
  chk_start_no_write: assert property (acc_start |=>
    $stable(s.shadow))
    else $error("write taken with command");
  chk_idle_no_write: assert property (!acc_wr |=>
    $stable(s.shadow))
    else $error("registers changed without write");
  chk_read_b2: assert property (acc_rd && !acc_start && s.ptr == OFS_B2 |=>
    acc_rdata == $past(s.shadow.b2))
    else $error("byte 2 readback wrong");
  chk_read_b3: assert property (acc_rd && !acc_start && s.ptr == OFS_B3 |=>
    acc_rdata == $past(s.shadow.b3))
    else $error("byte 3 readback wrong");
  chk_read_b4: assert property (acc_rd && !acc_start && s.ptr == OFS_B4 |=>
    acc_rdata == $past(s.shadow.b4))
    else $error("byte 4 readback wrong");
  chk_read_b5: assert property (acc_rd && !acc_start && s.ptr == OFS_B5 |=>
    acc_rdata == $past(s.shadow.b5))
    else $error("byte 5 readback wrong");
  chk_read_b6: assert property (acc_rd && !acc_start && s.ptr == OFS_B6 |=>
    acc_rdata[7:3] == $past(s.shadow.b6[7:3]))
    else $error("byte 6 readback wrong");
  chk_low_unmapped: assert property (acc_rd && !acc_start && s.ptr < OFS_B2 |=>
    acc_rdata == READ_NONE)
    else $error("low unmapped read not zero");
  chk_test_apply: assert property (out_clk_edge |=>
    cfg.b6[B6_TEST_MODE] == $past(s.shadow.b6[B6_TEST_MODE]) && cfg.b6[B6_TEST_SEL] == $past(s.shadow.b6[B6_TEST_SEL]))
    else $error("test mode bits not applied");
  chk_sw_halt_seq: assert property (sw_halt_written_s ##1 quiet_boundary_s |=>
    stop.bus_stop == 4'hF)
    else $error("software halt not applied at boundary");
  chk_sw_run_seq: assert property (sw_run_written_s ##1 quiet_boundary_s ##0 bus_clock_halt_n |=>
    stop.bus_stop == 4'h0)
    else $error("software restart not applied at boundary");
  chk_stop_reset: assert property ($past(!rst_b) |->
    stop == '0 && !acc_rvalid && straps == STRAP_RST)
    else $error("stop or straps not cleared by reset");
  chk_cfg_reset: assert property ($past(!rst_b) |->
    cfg.b3 == RST_B3 && cfg.b5 == RST_B5 && s.shadow.b3 == RST_B3 && s.shadow.b5 == RST_B5)
    else $error("byte 3 or 5 reset value wrong");

endmodule // clock_output_control_regs
`default_nettype wire

//--- tb/host_model.sv
// Purpose: Host controller model driving the control byte port
// Assumes: Requests change at the falling edge of mclk
// Notes:   Reserved bits are forced by the host on writes to bytes 2 and 4
`timescale 1ns/1ns
`default_nettype none
module host_model
  import clk_ctrl_pkg::*;
(
  input  wire logic       mclk,
  output var  logic       acc_start,
  output var  logic [7:0] acc_cmd,
  output var  logic       acc_wr,
  output var  logic [7:0] acc_wdata,
  output var  logic       acc_rd,
  input  wire logic [7:0] acc_rdata,
  input  wire logic       acc_rvalid
);
  initial begin
    {acc_start, acc_wr, acc_rd} = 3'h0;
    {acc_cmd, acc_wdata} = 16'h0000;
  end
  task automatic cmd(input logic [7:0] c);
    @(negedge mclk) {acc_start, acc_cmd} = {1'b1, c};
    @(negedge mclk) {acc_start, acc_cmd} = {1'b0, ~c};
  endtask
  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    logic [7:0] v;
    v = (ofs == OFS_B2) ? (d | 8'h0D) : d;
    v = (ofs == OFS_B4) ? (v & 8'hCF) : v;
    @(negedge mclk) {acc_wr, acc_wdata} = {1'b1, v};
    @(negedge mclk) {acc_wr, acc_wdata} = {1'b0, ~v};
  endtask
  task automatic rd(output logic [8:0] q);
    @(negedge mclk) acc_rd = 1'b1;
    @(negedge mclk) acc_rd = 1'b0;
    q = {acc_rvalid, acc_rdata};
  endtask
endmodule // host_model
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the clock output control bytes
// Assumes: Inputs change at the falling edge of mclk
// Notes:   Rows hold offset, write data and expected readback
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import clk_ctrl_pkg::*;
  logic mclk, rst_b, acc_start, acc_wr, acc_rd, acc_rvalid, out_clk_edge;
  logic bus_clock_halt_n, processor_clock_halt_n, power_down_input, supply_good_n;
  logic freq_strap_a, freq_strap_b, freq_strap_c;
  logic [7:0] acc_cmd, acc_wdata, acc_rdata;
  logic [2:0] straps;
  cfg_t cfg;
  stop_t stop;
  logic [8:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [23:0] rows [6] = '{24'h02303D, 24'h03A5A5, 24'h04FFCF, 24'h055A5A, 24'h06FFFD, 24'h097700};
  logic [7:0] rst_val [5] = '{8'hFF, 8'h00, 8'h07, 8'h00, 8'h3D};
  host_model i_host_model(.mclk, .acc_start, .acc_cmd, .acc_wr, .acc_wdata, .acc_rd, .acc_rdata, .acc_rvalid);
  clock_output_control_regs i_clock_output_control_regs(.mclk, .rst_b, .acc_start, .acc_cmd, .acc_wr,
    .acc_wdata, .acc_rd, .acc_rdata, .acc_rvalid, .out_clk_edge, .bus_clock_halt_n, .processor_clock_halt_n,
    .power_down_input, .supply_good_n, .freq_strap_a, .freq_strap_b, .freq_strap_c, .cfg, .stop, .straps);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdb(input logic [6:0] o, input logic [7:0] e);
    i_host_model.cmd({1'b1, o});
    i_host_model.rd(q);
    chk("rdata", {31'h0, 1'b1, e}, {31'h0, q});
  endtask
  task automatic edge_pulse();
    @(negedge mclk) out_clk_edge = 1'b1;
    @(negedge mclk) out_clk_edge = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  initial begin
    {rst_b, out_clk_edge, power_down_input} = 3'h0;
    {bus_clock_halt_n, processor_clock_halt_n, supply_good_n} = 3'h7;
    {freq_strap_c, freq_strap_b, freq_strap_a} = 3'h5;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    supply_good_n = 1'b0;
    for (int i = 0; i < 5; i++) rdb(OFS_B2 + 7'(i), rst_val[i]);
    chk("straps", 40'h5, {37'h0, straps});
    for (int i = 0; i < 6; i++) begin
      i_host_model.cmd({1'b1, rows[i][22:16]});
      i_host_model.wr(rows[i][22:16], rows[i][15:8]);
      rdb(rows[i][22:16], rows[i][7:0]);
    end
    chk("cfg_hold", 40'h0, {32'h0, cfg.b3});
    edge_pulse();
    chk("cfg", 40'h3DA5CF5AF8, cfg);
    i_host_model.cmd(8'h00);
    repeat (3) i_host_model.rd(q);
    chk("block", 40'h13D, {31'h0, q});
    i_host_model.cmd({1'b1, OFS_B6});
    i_host_model.wr(OFS_B6, 8'hF0);
    {processor_clock_halt_n, power_down_input} = 2'h1;
    edge_pulse();
    chk("stop", {4'hF, 1'b1, 8'hA5, 8'h00, 6'h3F, 3'h7}, stop);
    i_host_model.wr(OFS_B6, 8'hF8);
    {processor_clock_halt_n, power_down_input} = 2'h2;
    edge_pulse();
    chk("restart", 40'h0, stop);
    bus_clock_halt_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk("hw_stop", {4'hF, 1'b1, 8'hA5}, {stop.bus_stop, stop.free_bus_stop, stop.ref_stop});
    end_sim();
  end
endmodule // testbench
`default_nettype wire
